// ---- design/hst_core.sv ----
// High speed edge timing core: reset gate, horizontal clocks, sample strobes, counters
`timescale 1ns/1ns
`default_nettype none
module hst_core (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        master_clock_in,
  input  wire logic        reference_clock_halving,
  input  wire logic [17:0] horizontal_output_drive_strength,
  input  wire logic [5:0]  rg_rise_code,
  input  wire logic [5:0]  rg_fall_code,
  input  wire logic        rg_polarity,
  input  wire logic [5:0]  hl_rise_code,
  input  wire logic [5:0]  hl_fall_code,
  input  wire logic        hl_polarity,
  input  wire logic [5:0]  h1_rise_code,
  input  wire logic [5:0]  h1_fall_code,
  input  wire logic        h1_polarity,
  input  wire logic [5:0]  h3_rise_code,
  input  wire logic [5:0]  h3_fall_code,
  input  wire logic        h3_polarity,
  input  wire logic [5:0]  ref_strobe_loc,
  input  wire logic [5:0]  data_strobe_loc,
  input  wire logic        master_mode,
  input  wire logic        ext_sync,
  input  wire logic [12:0] h_line_last,
  input  wire logic [11:0] v_field_last,
  input  wire logic        horizontal_sync_in,
  input  wire logic        vertical_sync_in,
  output logic             crystal_drive_out,
  output logic             reset_gate_clock,
  output logic             reset_gate_oe,
  output logic             horizontal_last_clock,
  output logic             horizontal_last_oe,
  output logic             horiz_phase1,
  output logic             horiz_phase1_oe,
  output logic             horiz_phase2,
  output logic             horiz_phase2_oe,
  output logic             horiz_phase3,
  output logic             horiz_phase3_oe,
  output logic             horiz_phase4,
  output logic             horiz_phase4_oe,
  output logic             reference_level_sample_strobe,
  output logic             data_level_sample_strobe,
  output logic             horizontal_sync_out,
  output logic             horizontal_sync_oe,
  output logic             vertical_sync_out,
  output logic             vertical_sync_oe,
  output logic [12:0]      pixel_count,
  output logic [11:0]      line_count
);

  // ==========================================================
  // Edge code decode
  // Quadrant in the top two bits, twelve positions below; out-of-range
  // low codes clamp so a bad write never produces a missing edge.
  function automatic logic [5:0] edge_pos(input logic [5:0] code);
    logic [3:0] low;
    logic [5:0] base;
    low  = (code[3:0] > hst_pkg::QUAD_MAX) ? hst_pkg::QUAD_MAX : code[3:0];
    base = 6'(code[5:4] * hst_pkg::QUAD_LEN);
    return 6'(base + {2'h0, low});
  endfunction

  // ==========================================================
  // Pixel period framing
  logic       mclk_d_ff;
  logic       half_ff;
  logic       run_ff;
  logic [5:0] pos_ff;
  logic       mclk_rise;
  logic       pix_start;

  assign mclk_rise = master_clock_in & ~mclk_d_ff;
  assign pix_start = mclk_rise & (~reference_clock_halving | half_ff);

  // Master clock history, halving toggle and crystal driver
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mclk_d_ff         <= 1'b0;
      half_ff           <= 1'b0;
      crystal_drive_out <= 1'b1;
    end else begin
      mclk_d_ff         <= master_clock_in;
      crystal_drive_out <= ~master_clock_in;
      if (mclk_rise) begin
        half_ff <= ~half_ff;
      end
    end
  end

  // Fine position counter; parks on the last step if the next start is late
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_ff <= hst_pkg::FIRST_POS;
      run_ff <= 1'b0;
    end else if (pix_start) begin
      pos_ff <= hst_pkg::FIRST_POS;
      run_ff <= 1'b1;
    end else if (pos_ff != hst_pkg::LAST_POS) begin
      pos_ff <= 6'(pos_ff + 6'h01);
    end
  end

  // ==========================================================
  // Programmable clocks: one generator per clock, same in both sync modes
  logic [5:0] rise_code [hst_pkg::NUM_PCLK];
  logic [5:0] fall_code [hst_pkg::NUM_PCLK];
  logic [hst_pkg::NUM_PCLK-1:0] pol_vec;
  logic [hst_pkg::NUM_PCLK-1:0] raw_ff;
  logic [hst_pkg::NUM_PCLK-1:0] nxt_raw;
  logic [hst_pkg::NUM_PCLK-1:0] pclk_ff;

  assign rise_code[hst_pkg::PC_RG] = rg_rise_code;
  assign fall_code[hst_pkg::PC_RG] = rg_fall_code;
  assign rise_code[hst_pkg::PC_HL] = hl_rise_code;
  assign fall_code[hst_pkg::PC_HL] = hl_fall_code;
  assign rise_code[hst_pkg::PC_H1] = h1_rise_code;
  assign fall_code[hst_pkg::PC_H1] = h1_fall_code;
  assign rise_code[hst_pkg::PC_H3] = h3_rise_code;
  assign fall_code[hst_pkg::PC_H3] = h3_fall_code;
  assign pol_vec = {h3_polarity, h1_polarity, hl_polarity, rg_polarity};

  // Rise wins when both positions coincide, so the clock is never stuck low
  for (genvar i = 0; i < hst_pkg::NUM_PCLK; i++) begin : g_pclk
    always_comb begin
      nxt_raw[i] = raw_ff[i];
      if (run_ff && pos_ff == edge_pos(rise_code[i])) begin
        nxt_raw[i] = 1'b1;
      end else if (run_ff && pos_ff == edge_pos(fall_code[i])) begin
        nxt_raw[i] = 1'b0;
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        raw_ff[i]  <= 1'b0;
        pclk_ff[i] <= 1'b0;
      end else begin
        raw_ff[i]  <= nxt_raw[i];
        pclk_ff[i] <= nxt_raw[i] ^ pol_vec[i];
      end
    end
  end

  // Complement phases get their own flops to avoid a gate in the pin path
  logic h2_ff;
  logic h4_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h2_ff <= 1'b1;
      h4_ff <= 1'b1;
    end else begin
      h2_ff <= ~(nxt_raw[hst_pkg::PC_H1] ^ pol_vec[hst_pkg::PC_H1]);
      h4_ff <= ~(nxt_raw[hst_pkg::PC_H3] ^ pol_vec[hst_pkg::PC_H3]);
    end
  end

  assign reset_gate_clock      = pclk_ff[hst_pkg::PC_RG];
  assign horizontal_last_clock = pclk_ff[hst_pkg::PC_HL];
  assign horiz_phase1          = pclk_ff[hst_pkg::PC_H1];
  assign horiz_phase3          = pclk_ff[hst_pkg::PC_H3];
  assign horiz_phase2          = h2_ff;
  assign horiz_phase4          = h4_ff;

  // ==========================================================
  // Driver enables: a zero drive field floats the pin
  logic [hst_pkg::NUM_DRV-1:0] oe_ff;
  for (genvar d = 0; d < hst_pkg::NUM_DRV; d++) begin : g_drv
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        oe_ff[d] <= 1'b0;
      end else begin
        oe_ff[d] <= horizontal_output_drive_strength[d*hst_pkg::DRV_W +: hst_pkg::DRV_W]
                    != hst_pkg::DRV_OFF;
      end
    end
  end

  assign reset_gate_oe      = oe_ff[hst_pkg::DRV_RG];
  assign horizontal_last_oe = oe_ff[hst_pkg::DRV_HL];
  assign horiz_phase1_oe    = oe_ff[hst_pkg::DRV_H1];
  assign horiz_phase2_oe    = oe_ff[hst_pkg::DRV_H2];
  assign horiz_phase3_oe    = oe_ff[hst_pkg::DRV_H3];
  assign horiz_phase4_oe    = oe_ff[hst_pkg::DRV_H4];

  // ==========================================================
  // Sample strobes, one fine step wide each pixel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reference_level_sample_strobe <= 1'b0;
      data_level_sample_strobe      <= 1'b0;
    end else begin
      reference_level_sample_strobe <= run_ff && pos_ff == edge_pos(ref_strobe_loc);
      data_level_sample_strobe      <= run_ff && pos_ff == edge_pos(data_strobe_loc);
    end
  end

  // ==========================================================
  // Line and field counters
  // Slave mode follows falling sync edges; master mode wraps at the
  // programmed last pixel and line, and the external pulse realigns both.
  logic hd_in_d_ff;
  logic vd_in_d_ff;
  logic hd_fall;
  logic vd_fall;
  assign hd_fall = hd_in_d_ff & ~horizontal_sync_in;
  assign vd_fall = vd_in_d_ff & ~vertical_sync_in;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hd_in_d_ff <= 1'b1;
      vd_in_d_ff <= 1'b1;
    end else begin
      hd_in_d_ff <= horizontal_sync_in;
      vd_in_d_ff <= vertical_sync_in;
    end
  end

  logic [12:0] h_cnt_ff;
  logic [11:0] v_cnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h_cnt_ff <= hst_pkg::H_ZERO;
      v_cnt_ff <= hst_pkg::V_ZERO;
    end else if (master_mode) begin
      if (ext_sync) begin
        h_cnt_ff <= hst_pkg::H_ZERO;
        v_cnt_ff <= hst_pkg::V_ZERO;
      end else if (pix_start) begin
        if (h_cnt_ff >= h_line_last) begin
          h_cnt_ff <= hst_pkg::H_ZERO;
          v_cnt_ff <= (v_cnt_ff >= v_field_last) ? hst_pkg::V_ZERO
                                                 : 12'(v_cnt_ff + hst_pkg::V_ONE);
        end else begin
          h_cnt_ff <= 13'(h_cnt_ff + hst_pkg::H_ONE);
        end
      end
    end else begin
      if (vd_fall) begin
        v_cnt_ff <= hst_pkg::V_ZERO;
      end else if (hd_fall) begin
        v_cnt_ff <= 12'(v_cnt_ff + hst_pkg::V_ONE);
      end
      if (hd_fall) begin
        h_cnt_ff <= hst_pkg::H_ZERO;
      end else if (pix_start) begin
        h_cnt_ff <= 13'(h_cnt_ff + hst_pkg::H_ONE);
      end
    end
  end

  assign pixel_count = h_cnt_ff;
  assign line_count  = v_cnt_ff;

  // Sync pins: active-low pulses driven only in master mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      horizontal_sync_out <= 1'b1;
      vertical_sync_out   <= 1'b1;
      horizontal_sync_oe  <= 1'b0;
      vertical_sync_oe    <= 1'b0;
    end else begin
      horizontal_sync_out <= ~(h_cnt_ff == hst_pkg::H_ZERO);
      vertical_sync_out   <= ~(v_cnt_ff == hst_pkg::V_ZERO);
      horizontal_sync_oe  <= master_mode;
      vertical_sync_oe    <= master_mode;
    end
  end

  // ==========================================================
  // Assertions
  sequence s_ext_sync;
    master_mode && ext_sync;
  endsequence
  sequence s_counters_zero;
    h_cnt_ff == hst_pkg::H_ZERO && v_cnt_ff == hst_pkg::V_ZERO;
  endsequence

  a_pos_restart: assert property (@(posedge clk) disable iff (!nrst)
    pix_start |=> pos_ff == hst_pkg::FIRST_POS)
    else $error("Fine position did not restart at pixel start");
  a_pos_step: assert property (@(posedge clk) disable iff (!nrst)
    !pix_start && pos_ff != hst_pkg::LAST_POS |=> pos_ff == 6'($past(pos_ff) + 6'h01))
    else $error("Fine position did not advance by one");
  a_halving_skip: assert property (@(posedge clk) disable iff (!nrst)
    reference_clock_halving && mclk_rise && !half_ff |-> !pix_start)
    else $error("Halving did not skip a master clock rise");
  a_xtal_inverse: assert property (@(posedge clk) disable iff (!nrst)
    ##1 crystal_drive_out == !$past(master_clock_in))
    else $error("Crystal drive is not the inverse of the master clock");
  a_phase_compl: assert property (@(posedge clk) disable iff (!nrst)
    horiz_phase2 == !horiz_phase1 && horiz_phase4 == !horiz_phase3)
    else $error("Complement phase mismatch");
  a_rise_sets: assert property (@(posedge clk) disable iff (!nrst)
    run_ff && pos_ff == edge_pos(rg_rise_code)
    |=> reset_gate_clock == !$past(rg_polarity))
    else $error("Reset gate not set at its rise position");
  a_fall_clears: assert property (@(posedge clk) disable iff (!nrst)
    run_ff && pos_ff == edge_pos(h1_fall_code) && pos_ff != edge_pos(h1_rise_code)
    |=> horiz_phase1 == $past(h1_polarity))
    else $error("Phase one not cleared at its fall position");
  a_drive_off: assert property (@(posedge clk) disable iff (!nrst)
    horizontal_output_drive_strength[2:0] == hst_pkg::DRV_OFF |=> !reset_gate_oe)
    else $error("Reset gate driver enabled at zero drive");
  a_strobe_loc: assert property (@(posedge clk) disable iff (!nrst)
    reference_level_sample_strobe |-> $past(pos_ff) == edge_pos($past(ref_strobe_loc)))
    else $error("Reference strobe at wrong position");
  a_ext_resync: assert property (@(posedge clk) disable iff (!nrst)
    s_ext_sync |=> s_counters_zero ##1 (!horizontal_sync_out && !vertical_sync_out))
    else $error("External sync did not realign counters and sync outputs");
  a_slave_hd: assert property (@(posedge clk) disable iff (!nrst)
    !master_mode && hd_fall |=> h_cnt_ff == hst_pkg::H_ZERO ##1 !horizontal_sync_oe)
    else $error("Slave line start not followed");
endmodule
`default_nettype wire

// ---- design/hst_pkg.sv ----
// Constants for the high speed edge timing core
package hst_pkg;
  // ==========================================================
  // Edge grid
  localparam int         EDGE_STEPS = 48;        // Fine steps per pixel period
  localparam logic [5:0] LAST_POS   = 6'h2F;     // Position 47
  localparam logic [5:0] FIRST_POS  = 6'h00;
  localparam logic [5:0] QUAD_LEN   = 6'h0C;     // Twelve positions a quadrant
  localparam logic [3:0] QUAD_MAX   = 4'hB;      // Last valid low code in a quadrant
  // ==========================================================
  // Programmable clocks: reset gate, last clock, phase one, phase three
  localparam int NUM_PCLK = 4;
  localparam int PC_RG    = 0;
  localparam int PC_HL    = 1;
  localparam int PC_H1    = 2;
  localparam int PC_H3    = 3;
  // ==========================================================
  // Drive strength word: six 3-bit fields
  localparam int         DRV_W     = 3;
  localparam int         NUM_DRV   = 6;
  localparam logic [2:0] DRV_OFF   = 3'h0;       // Driver in high impedance
  localparam int         DRV_RG    = 0;          // Bits [2:0]
  localparam int         DRV_HL    = 1;          // Bits [5:3]
  localparam int         DRV_H1    = 2;          // Bits [8:6]
  localparam int         DRV_H2    = 3;          // Bits [11:9]
  localparam int         DRV_H3    = 4;          // Bits [14:12]
  localparam int         DRV_H4    = 5;          // Bits [17:15]
  // ==========================================================
  // Register offsets on the serial map
  localparam logic [7:0] REG_HALVING_OFS = 8'h30;
  localparam logic [7:0] REG_DRIVE_OFS   = 8'h36;
  // ==========================================================
  // Line and field counters
  localparam int          H_CNT_W = 13;          // 8192 pixels per line
  localparam int          V_CNT_W = 12;          // 4096 lines per field
  localparam logic [12:0] H_ZERO  = 13'h0000;
  localparam logic [11:0] V_ZERO  = 12'h000;
  localparam logic [12:0] H_ONE   = 13'h0001;
  localparam logic [11:0] V_ONE   = 12'h001;
endpackage

// ---- bench/hst_ccd_sensor.sv ----
// Sensor-side model of the reset gate and horizontal clock inputs
`timescale 1ns/1ns
`default_nettype none
module hst_ccd_sensor (
  input  wire logic       clk,
  input  wire logic [5:0] drive_level,
  input  wire logic [5:0] drive_oe,
  output logic      [5:0] pin_level
);
  logic [5:0] float_ff = 6'h15;

  // ==========================================================
  // Pin levels
  // Sensor inputs have no pull, so an undriven pin shows a level that flips
  // every cycle; a stale value must never pass for a driven one
  always @(posedge clk) begin
    float_ff <= ~pin_level;
  end
  assign pin_level = (drive_level & drive_oe) | (float_ff & ~drive_oe);
endmodule
`default_nettype wire

// ---- bench/hst_core_test.sv ----
// Self-checking bench for the high speed edge timing core
`timescale 1ns/1ns
`default_nettype none
module hst_core_test;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        mci = 1'b0;
  logic        halv = 1'b0;
  logic        msel = 1'b1;
  logic        xs = 1'b0;
  logic        hin = 1'b1;
  logic        vin = 1'b1;
  logic [5:0]  rc [4];
  logic [5:0]  fc [4];
  logic [3:0]  pl = 4'h0;
  logic [5:0]  sl = 6'h00;
  logic [5:0]  dl = 6'h00;
  logic [17:0] drv = 18'h3FFFF;
  logic        co, rg, hl, h1, h2, h3, h4, sr, sd, hso, hoe, vso, voe;
  wire logic [5:0] oe, pins;
  logic [12:0] pc;
  logic [11:0] lc;
  logic        mq_ff, run_ff, exo_ff;
  logic [3:0]  ec_ff, er_ff;
  logic [1:0]  es_ff;
  logic [5:0]  eo_ff;
  int          pos_ff, fails = 0, check_count = 0, mcnt = 0;
  wire logic [8:0] dv = {co, rg, hl, h1, h2, h3, h4, sr, sd};
  wire logic [8:0] ev = {exo_ff, ec_ff[0], ec_ff[1], ec_ff[2], ~ec_ff[2], ec_ff[3],
                         ~ec_ff[3], es_ff};
  wire logic [5:0] outs = {h4, h3, h2, h1, hl, rg};
  wire logic [5:0] eouts = {~ec_ff[3], ec_ff[3], ~ec_ff[2], ec_ff[2], ec_ff[1], ec_ff[0]};

  hst_core hst_core_i (.clk(clk), .nrst(nrst), .master_clock_in(mci),
    .reference_clock_halving(halv), .horizontal_output_drive_strength(drv),
    .rg_rise_code(rc[0]), .rg_fall_code(fc[0]), .rg_polarity(pl[0]),
    .hl_rise_code(rc[1]), .hl_fall_code(fc[1]), .hl_polarity(pl[1]),
    .h1_rise_code(rc[2]), .h1_fall_code(fc[2]), .h1_polarity(pl[2]),
    .h3_rise_code(rc[3]), .h3_fall_code(fc[3]), .h3_polarity(pl[3]),
    .ref_strobe_loc(sl), .data_strobe_loc(dl), .master_mode(msel), .ext_sync(xs),
    .h_line_last(13'h0003), .v_field_last(12'h001), .horizontal_sync_in(hin),
    .vertical_sync_in(vin), .crystal_drive_out(co), .reset_gate_clock(rg),
    .reset_gate_oe(oe[0]), .horizontal_last_clock(hl), .horizontal_last_oe(oe[1]),
    .horiz_phase1(h1), .horiz_phase1_oe(oe[2]), .horiz_phase2(h2),
    .horiz_phase2_oe(oe[3]), .horiz_phase3(h3), .horiz_phase3_oe(oe[4]),
    .horiz_phase4(h4), .horiz_phase4_oe(oe[5]), .reference_level_sample_strobe(sr),
    .data_level_sample_strobe(sd), .horizontal_sync_out(hso), .horizontal_sync_oe(hoe),
    .vertical_sync_out(vso), .vertical_sync_oe(voe), .pixel_count(pc), .line_count(lc));

  hst_ccd_sensor hst_ccd_sensor_i (.clk(clk), .drive_level(outs), .drive_oe(oe),
    .pin_level(pins));

  // ==========================================================
  // Clocks: master clock period of 48 steps, so one pixel per period
  always #5 clk = ~clk;
  always @(negedge clk) begin
    mcnt <= (mcnt == 23) ? 0 : mcnt + 1;
    if (mcnt == 23) mci <= ~mci;
  end

  // Edge code to grid position; low codes past eleven sit on the last step of their quadrant
  function automatic int dec(input logic [5:0] c);
    return c[5:4] * 12 + ((c[3:0] > 4'hB) ? 11 : c[3:0]);
  endfunction

  // Next raw level of clock k: rise wins over fall, otherwise it holds
  function automatic logic nr(input int k);
    if (run_ff && pos_ff == dec(rc[k])) return 1'b1;
    if (run_ff && pos_ff == dec(fc[k])) return 1'b0;
    return er_ff[k];
  endfunction

  // Reference timing, valid with halving off; the rise is seen at the edge
  // that samples it, and polarity is applied every cycle so a late change shows
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {mq_ff, run_ff, er_ff, ec_ff, es_ff, eo_ff} <= 18'h00000;
      exo_ff <= 1'b1;
      pos_ff <= 0;
    end else begin
      mq_ff <= mci;
      exo_ff <= ~mci;
      if (mci && !mq_ff) begin
        pos_ff <= 0;
        run_ff <= 1'b1;
      end else if (pos_ff < 47) begin
        pos_ff <= pos_ff + 1;
      end
      for (int k = 0; k < 4; k++) begin
        er_ff[k] <= nr(k);
        ec_ff[k] <= nr(k) ^ pl[k];
      end
      es_ff <= {run_ff && pos_ff == dec(sl), run_ff && pos_ff == dec(dl)};
      for (int k = 0; k < 6; k++) eo_ff[k] <= |drv[3*k +: 3];
    end
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare every clock, strobe, enable and driven pin for n pixels
  task automatic run_px(input int n);
    repeat (n * 48) begin
      @(negedge clk);
      chk("clocks", 32'(ev), 32'(dv));
      chk("enables", 32'(eo_ff), 32'(oe));
      chk("pins", 32'(eouts & eo_ff), 32'(pins & eo_ff));
    end
  endtask

  task automatic wait_px(input int n);
    repeat (n) @(posedge mci);
    repeat (24) @(negedge clk);
  endtask

  task automatic sync_chk(input logic [3:0] hv, input logic [12:0] p, input logic [11:0] l);
    chk("sync", {hv, 3'h0, p, l}, {hso, vso, hoe, voe, 3'h0, pc, lc});
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_edges;
    rc = '{6'h00, 6'h05, 6'h11, 6'h34};
    fc = '{6'h20, 6'h30, 6'h03, 6'h0B};
    pl = 4'hA;
    sl = 6'h03;
    dl = 6'h23;
    run_px(2);
  endtask

  // Every quadrant, both ends of it, and the undefined low codes
  task automatic t_codes;
    logic [5:0] tab [13] = '{6'h00, 6'h0B, 6'h0C, 6'h0F, 6'h10, 6'h1B, 6'h1C,
                             6'h20, 6'h2B, 6'h2F, 6'h30, 6'h3B, 6'h3F};
    foreach (tab[i]) begin
      rc = '{4{tab[i]}};
      fc = '{4{tab[i] ^ 6'h20}};
      sl = tab[i];
      run_px(1);
    end
  endtask

  task automatic t_drive;
    for (int v = 0; v < 8; v++) begin
      for (int k = 0; k < 6; k++) drv[3*k +: 3] = 3'(v + k);
      run_px(1);
    end
  endtask

  task automatic t_twophase;
    rc[3] = rc[2];
    fc[3] = fc[2];
    pl[3] = pl[2];
    run_px(1);
    repeat (48) begin
      @(negedge clk);
      chk("two phase", 32'({h1, h2}), 32'({h3, h4}));
    end
  endtask

  // External sync clears counters; line of 4 pixels, field of 2 lines
  task automatic t_master;
    msel = 1'b1;
    wait_px(1);
    xs = 1'b1;
    @(negedge clk);
    xs = 1'b0;
    repeat (2) @(negedge clk);
    sync_chk(4'h3, 13'h0000, 12'h000);
    wait_px(1);
    sync_chk(4'hB, 13'h0001, 12'h000);
    wait_px(3);
    sync_chk(4'h7, 13'h0000, 12'h001);
    wait_px(4);
    sync_chk(4'h3, 13'h0000, 12'h000);
  endtask

  task automatic t_slave;
    msel = 1'b0;
    wait_px(1);
    vin = 1'b0;
    repeat (2) @(negedge clk);
    vin = 1'b1;
    hin = 1'b0;
    repeat (2) @(negedge clk);
    hin = 1'b1;
    repeat (2) @(negedge clk);
    sync_chk(4'h4, 13'h0000, 12'h001);
    wait_px(1);
    sync_chk(4'hC, 13'h0001, 12'h001);
    run_px(1);
  endtask

  // Halving: one pixel every two master periods, counted by strobes
  task automatic t_halving;
    int n = 0;
    halv = 1'b1;
    sl = 6'h05;
    wait_px(2);
    repeat (960) begin
      @(negedge clk);
      if (sr === 1'b1) n++;
    end
    chk("strobes in twenty periods", 32'h0000000A, 32'(n));
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is near 2800 cycles; the watchdog allows about seven times that
  initial begin
    #200000;
    fails++;
    wrap_up;
  end

  initial begin
    rc = '{4{6'h00}};
    fc = '{4{6'h20}};
    repeat (10) @(negedge clk);
    chk("reset clocks", 32'h00000114, 32'(dv));
    chk("reset sync", 32'h00000003, 32'({oe, hso, vso}));
    chk("reset counts", 32'h0, 32'({pc, lc}));
    nrst = 1'b1;
    t_edges;
    t_codes;
    t_drive;
    t_twophase;
    t_master;
    t_slave;
    t_halving;
    wrap_up;
  end
endmodule
`default_nettype wire
